//--- src/stio_map.svh
// Constants for the status and trigger pin block.
`ifndef STIO_MAP_SVH
`define STIO_MAP_SVH
`define STIO_CLK_MHZ 100
`define STIO_TRIG_LOW_US 30
`define STIO_TRIG_LOW_CYC (`STIO_TRIG_LOW_US * `STIO_CLK_MHZ)
`define STIO_FN_STATUS 2'h0
`define STIO_FN_INPUT 2'h1
`define STIO_FN_OUTPUT 2'h2
`define STIO_FN_TRIG 2'h3
`define STIO_OUT_ONE 2'h0
`define STIO_OUT_ZERO 2'h1
`define STIO_OUT_PWM 2'h2
`define STIO_TGT_METER 2'h0
`define STIO_TGT_DLOG 2'h1
`define STIO_TGT_LIST 2'h2
`endif

//--- src/stio_pkg.sv
// Types for the status and trigger pin block.
package stio_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_WAIT = 3'b100
  } stio_tst_t;
endpackage

//--- src/stio_pwm.sv
// PWM generator shared by both configurable pins.
`timescale 1ns/1ns
module stio_pwm #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  output logic pwm
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic pwm_r;
  logic pwm_nxt;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A period of zero holds the counter at zero, so the output is high whenever duty is nonzero.
  always_comb
  begin
    cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
    if (cnt_r >= period - {{(W-1){1'b0}}, 1'b1} || period == '0)
      cnt_nxt = '0;
    pwm_nxt = cnt_nxt < duty;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      pwm_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm = pwm_r;
endmodule

//--- src/stio_top.sv
// Status pin and bidirectional trigger pin logic.
// Function
// - Per-pin polarity setting inverts every level driven or received.
// - Status mode, normal polarity: high when output off, low when on.
// - Inverted polarity in status mode gives the exact complement.
// - Output value 1 drives low normally, high when inverted.
// - Output value 0 drives high normally, low when inverted.
// - Output mode drives constant 1, constant 0 or configurable PWM.
// - Input mode releases the pin and reports the sampled level.
// - Trigger pin is bidirectional, selectable trigger out or trigger in.
// - Incoming trigger pulse starts meter, data logging or sequence run.
// - After reset status pin is status mode, trigger pin trigger mode.
// - Trigger out mode emits a pulse when a triggered operation starts.
// - Trigger pulses hold low at least 30us, both ways.
`timescale 1ns/1ns
`include "stio_map.svh"
module stio_top #(
  parameter int PW = 16,
  parameter int LOW_CYC = `STIO_TRIG_LOW_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load_on,
  input wire logic [1:0] st_fn,
  input wire logic st_inv,
  input wire logic [1:0] st_out_sel,
  input wire logic st_pin_in,
  output logic st_pin_out,
  output logic st_pin_oe_n,
  output logic st_level,
  input wire logic [1:0] tr_fn,
  input wire logic tr_inv,
  input wire logic tr_dir_out,
  input wire logic [1:0] tr_target,
  input wire logic [1:0] tr_out_sel,
  input wire logic meter_armed,
  input wire logic trig_event,
  input wire logic tr_pin_in,
  output logic tr_pin_out,
  output logic tr_pin_oe_n,
  output logic tr_level,
  output logic start_meter,
  output logic start_dlog,
  output logic start_list,
  input wire logic [PW-1:0] pwm_period,
  input wire logic [PW-1:0] pwm_duty
);
  localparam int CW = $clog2(LOW_CYC + 1);
  localparam logic [CW-1:0] LOW_MAX = CW'(LOW_CYC - 1);

  logic pwm;
  logic [1:0] sy_st_r;
  logic [1:0] sy_tr_r;
  logic tr_prev_r;
  logic tr_prev_nxt;
  logic [CW-1:0] in_cnt_r;
  logic [CW-1:0] in_cnt_nxt;
  logic in_fired_r;
  logic in_fired_nxt;
  stio_pkg::stio_tst_t ost_r;
  stio_pkg::stio_tst_t ost_nxt;
  logic [CW-1:0] ocnt_r;
  logic [CW-1:0] ocnt_nxt;
  logic st_out_r, st_out_nxt, st_oe_r, st_oe_nxt, st_lv_r, st_lv_nxt;
  logic tr_out_r, tr_out_nxt, tr_oe_r, tr_oe_nxt, tr_lv_r, tr_lv_nxt;
  logic [2:0] start_r;
  logic [2:0] start_nxt;
  logic tr_in_lvl;
  logic tr_in_mode;
  logic tr_out_mode;

  stio_pwm #(.W(PW)) i_stio_pwm (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .period(pwm_period),
    .duty(pwm_duty),
    .pwm(pwm)
  );

  // ----------------------------------------------------------------
  // Pin level helper
  // ----------------------------------------------------------------
  // Logic 1 is the electrical low level, so the value is inverted once.
  function automatic logic gen_level(input logic [1:0] sel,
                                     input logic p);
    logic v;
    v = 1'b0;
    case (sel)
      `STIO_OUT_ONE: v = 1'b1;
      `STIO_OUT_ZERO: v = 1'b0;
      `STIO_OUT_PWM: v = p;
      default: v = 1'b0;
    endcase
    gen_level = ~v;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sy_st_r <= 2'b11;
      sy_tr_r <= 2'b11;
    end
    else if (ce)
    begin
      sy_st_r <= {sy_st_r[0], st_pin_in};
      sy_tr_r <= {sy_tr_r[0], tr_pin_in};
    end
  end

  // ----------------------------------------------------------------
  // Trigger input qualification
  // ----------------------------------------------------------------
  // Active level is low after polarity; a pulse counts once it has held
  // the low level long enough, so glitches never start anything.
  // Counting opens only on a falling edge, so a line that is already low
  // when trigger input is selected is not taken for a pulse.
  assign tr_in_mode = (tr_fn == `STIO_FN_TRIG) && !tr_dir_out;
  assign tr_out_mode = (tr_fn == `STIO_FN_TRIG) && tr_dir_out;
  assign tr_in_lvl = sy_tr_r[1] ^ tr_inv;

  always_comb
  begin
    tr_prev_nxt = tr_in_lvl;
    in_cnt_nxt = in_cnt_r;
    in_fired_nxt = in_fired_r;
    start_nxt = 3'b000;
    if (!tr_in_mode || tr_in_lvl)
    begin
      in_cnt_nxt = '0;
      in_fired_nxt = 1'b0;
    end
    else if (!in_fired_r && (tr_prev_r || in_cnt_r != '0))
    begin
      if (in_cnt_r >= LOW_MAX)
      begin
        in_fired_nxt = 1'b1;
        case (tr_target)
          `STIO_TGT_METER: start_nxt[0] = meter_armed;
          `STIO_TGT_DLOG: start_nxt[1] = 1'b1;
          `STIO_TGT_LIST: start_nxt[2] = 1'b1;
          default: start_nxt = 3'b000;
        endcase
      end
      else
        in_cnt_nxt = in_cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Trigger output pulse
  // ----------------------------------------------------------------
  always_comb
  begin
    ost_nxt = ost_r;
    ocnt_nxt = ocnt_r;
    case (ost_r)
      stio_pkg::ST_IDLE:
      begin
        if (tr_out_mode && trig_event)
        begin
          ost_nxt = stio_pkg::ST_LOW;
          ocnt_nxt = '0;
        end
      end
      stio_pkg::ST_LOW:
      begin
        if (ocnt_r >= LOW_MAX)
          ost_nxt = stio_pkg::ST_WAIT;
        else
          ocnt_nxt = ocnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      stio_pkg::ST_WAIT:
        ost_nxt = stio_pkg::ST_IDLE;
      default:
        ost_nxt = stio_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_comb
  begin
    st_out_nxt = 1'b1;
    st_oe_nxt = 1'b0;
    case (st_fn)
      `STIO_FN_STATUS: st_out_nxt = ~load_on;
      `STIO_FN_INPUT: st_oe_nxt = 1'b1;
      `STIO_FN_OUTPUT: st_out_nxt = gen_level(st_out_sel, pwm);
      default: st_out_nxt = ~load_on;
    endcase
    st_out_nxt = st_out_nxt ^ st_inv;
    st_lv_nxt = sy_st_r[1] ^ st_inv;
    tr_out_nxt = 1'b1;
    tr_oe_nxt = 1'b0;
    case (tr_fn)
      `STIO_FN_TRIG:
      begin
        tr_oe_nxt = !tr_dir_out;
        tr_out_nxt = (ost_r != stio_pkg::ST_LOW);
      end
      `STIO_FN_INPUT: tr_oe_nxt = 1'b1;
      `STIO_FN_OUTPUT: tr_out_nxt = gen_level(tr_out_sel, pwm);
      default: tr_oe_nxt = 1'b1;
    endcase
    tr_out_nxt = tr_out_nxt ^ tr_inv;
    tr_lv_nxt = tr_in_lvl;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tr_prev_r <= 1'b1;
      in_cnt_r <= '0;
      in_fired_r <= 1'b0;
      start_r <= 3'b000;
      ost_r <= stio_pkg::ST_IDLE;
      ocnt_r <= '0;
      st_out_r <= 1'b1;
      st_oe_r <= 1'b0;
      st_lv_r <= 1'b1;
      tr_out_r <= 1'b1;
      tr_oe_r <= 1'b1;
      tr_lv_r <= 1'b1;
    end
    else if (ce)
    begin
      tr_prev_r <= tr_prev_nxt;
      in_cnt_r <= in_cnt_nxt;
      in_fired_r <= in_fired_nxt;
      start_r <= start_nxt;
      ost_r <= ost_nxt;
      ocnt_r <= ocnt_nxt;
      st_out_r <= st_out_nxt;
      st_oe_r <= st_oe_nxt;
      st_lv_r <= st_lv_nxt;
      tr_out_r <= tr_out_nxt;
      tr_oe_r <= tr_oe_nxt;
      tr_lv_r <= tr_lv_nxt;
    end
  end

  assign st_pin_out = st_out_r;
  assign st_pin_oe_n = st_oe_r;
  assign st_level = st_lv_r;
  assign tr_pin_out = tr_out_r;
  assign tr_pin_oe_n = tr_oe_r;
  assign tr_level = tr_lv_r;
  assign start_meter = start_r[0];
  assign start_dlog = start_r[1];
  assign start_list = start_r[2];
endmodule

//--- test/stio_top_assertions.sv
// Checker of the pin block ports.
`timescale 1ns/1ns
module stio_chk #(
  parameter int LOW_CYC = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load_on,
  input wire logic [1:0] st_fn,
  input wire logic st_inv,
  input wire logic [1:0] st_out_sel,
  input wire logic st_pin_in,
  input wire logic st_pin_out,
  input wire logic st_pin_oe_n,
  input wire logic st_level,
  input wire logic [1:0] tr_fn,
  input wire logic tr_inv,
  input wire logic tr_dir_out,
  input wire logic [1:0] tr_target,
  input wire logic meter_armed,
  input wire logic trig_event,
  input wire logic tr_pin_in,
  input wire logic tr_pin_out,
  input wire logic tr_pin_oe_n,
  input wire logic start_meter,
  input wire logic start_dlog,
  input wire logic start_list
);
  // ---------
  // Pin rules
  // ---------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic st_any = start_meter | start_dlog | start_list;
  property p_stat;
    ce && st_fn == 2'h0 |=> st_pin_out == ($past(st_inv) ^ !$past(load_on));
  endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_one;
    ce && st_fn == 2'h2 && st_out_sel == 2'h0 |=> st_pin_out == $past(st_inv);
  endproperty
  a_one: assert property (p_one) else $error("one");
  property p_zero;
    ce && st_fn == 2'h2 && st_out_sel == 2'h1 |=> st_pin_out != $past(st_inv);
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_rel;
    ce && st_fn == 2'h1 |=> st_pin_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  sequence s_fire;
    ce && tr_fn == 2'h3 && tr_dir_out && trig_event && tr_pin_out != tr_inv;
  endsequence
  // The repetition counts match the LOW_CYC of 8 that the bench uses.
  property p_pulse;
    s_fire ##0 $past(tr_pin_out) != $past(tr_inv) |-> ##2
      (tr_pin_out == tr_inv && !tr_pin_oe_n)[*8] ##1 tr_pin_out != tr_inv;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_once;
    st_any |-> $onehot({start_meter, start_dlog, start_list}) &&
      tr_target == {start_list, start_dlog} ##1 !st_any;
  endproperty
  a_once: assert property (p_once) else $error("start");
  property p_cause;
    st_any |-> $past(tr_pin_in, 3) == tr_inv &&
      $past(tr_pin_in, 8) == tr_inv && (!start_meter || meter_armed);
  endproperty
  a_cause: assert property (p_cause) else $error("cause");
  property p_lvl;
    (ce && $stable(st_pin_in) && $stable(st_inv))[*4] |->
      st_level == (st_pin_in ^ st_inv);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level");
endmodule
bind stio_top stio_chk #(.LOW_CYC(LOW_CYC)) i_stio_chk (.core_clk, .reset,
  .ce, .load_on, .st_fn, .st_inv, .st_out_sel, .st_pin_in, .st_pin_out,
  .st_pin_oe_n, .st_level, .tr_fn, .tr_inv, .tr_dir_out, .tr_target,
  .meter_armed, .trig_event, .tr_pin_in, .tr_pin_out, .tr_pin_oe_n,
  .start_meter, .start_dlog, .start_list);

//--- test/stio_far.sv
// Model of the outside instrument on one pin.
`timescale 1ns/1ns
module stio_far (
  input wire logic core_clk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_in
);
  logic drv_lvl = 1'b1;
  assign pin_in = pin_oe_n ? drv_lvl : pin_out;
  task automatic pulse(input int n, input logic act);
    @(negedge core_clk);
    drv_lvl = act;
    repeat (n) @(negedge core_clk);
    drv_lvl = !act;
  endtask
endmodule

//--- test/stio_top_bench.sv
// Random and corner tests of the pin block.
`timescale 1ns/1ns
module stio_top_bench;
  localparam int LC = 8;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic load_on, st_inv, st_pin_in, st_pin_out, st_pin_oe_n, st_level;
  logic tr_inv, tr_dir_out, meter_armed, trig_event, tr_pin_in, tr_level;
  logic tr_pin_out, tr_pin_oe_n, start_meter, start_dlog, start_list;
  logic [1:0] st_fn, st_out_sel, tr_fn, tr_target, tr_out_sel;
  logic [15:0] pwm_period, pwm_duty;
  int fails = 0;
  int n_checks = 0;
  int seed = 17154;
  int k, n, m, cnt[3], base[3];
  stio_top #(.LOW_CYC(LC)) i_stio_top (.core_clk, .reset, .ce, .load_on,
    .st_fn, .st_inv, .st_out_sel, .st_pin_in, .st_pin_out, .st_pin_oe_n,
    .st_level, .tr_fn, .tr_inv, .tr_dir_out, .tr_target, .tr_out_sel,
    .meter_armed, .trig_event, .tr_pin_in, .tr_pin_out, .tr_pin_oe_n,
    .tr_level, .start_meter, .start_dlog, .start_list, .pwm_period,
    .pwm_duty);
  stio_far i_stio_far_s (.core_clk, .pin_out(st_pin_out),
    .pin_oe_n(st_pin_oe_n), .pin_in(st_pin_in));
  stio_far i_stio_far_t (.core_clk, .pin_out(tr_pin_out),
    .pin_oe_n(tr_pin_oe_n), .pin_in(tr_pin_in));
  always #5 core_clk = !core_clk;
  always @(posedge core_clk)
  begin
    cnt[0] += start_meter;
    cnt[1] += start_dlog;
    cnt[2] += start_list;
  end
  // -----
  // Tasks
  // -----
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  // Logic one is the low level, so the inverted case drives it high.
  function automatic logic drv(input logic [1:0] sel, input logic inv);
    return (sel == 2'h0) ? inv : !inv;
  endfunction
  // ---------
  // Scenarios
  // ---------
  initial
  begin
    {load_on, st_inv, tr_inv, tr_dir_out, meter_armed, trig_event} = '0;
    {st_fn, st_out_sel, tr_target, tr_out_sel, pwm_period, pwm_duty} = '0;
    tr_fn = 2'h3;
    cyc(3);
    reset = 1'b0;
    cyc(2);
    chk("st_pin_out", st_pin_out, 1'b1);
    chk("tr_pin_oe_n", tr_pin_oe_n, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      {load_on, st_inv} = k[1:0];
      cyc(2);
      chk("status", st_pin_out, drv({1'b0, !load_on}, st_inv));
    end
    ce = 1'b0;
    load_on = 1'b0;
    cyc(3);
    chk("freeze", st_pin_out, 1'b1);
    ce = 1'b1;
    cyc(2);
    chk("thaw", st_pin_out, drv(2'h1, st_inv));
    $display("status test done");
    {st_fn, tr_fn} = 4'ha;
    for (k = 0; k < 4; k++)
    begin
      {st_out_sel, st_inv} = k[2:0];
      {tr_out_sel, tr_inv} = k[2:0];
      cyc(2);
      chk("st_out", st_pin_out, drv(st_out_sel, st_inv));
      chk("tr_out", tr_pin_out, drv(tr_out_sel, tr_inv));
    end
    {st_out_sel, st_inv} = 3'h4;
    {tr_out_sel, tr_inv} = 3'h5;
    repeat (2)
    begin
      pwm_period = 16'h0002 + 16'($unsigned($random(seed)) % 14);
      pwm_duty = 16'($unsigned($random(seed)) % pwm_period);
      cyc(40);
      n = 0;
      k = 0;
      repeat (4 * pwm_period)
      begin
        cyc(1);
        n += !st_pin_out;
        k += tr_pin_out;
      end
      chk("pwm", 16'(n), 16'(4 * pwm_duty));
      chk("tr_pwm", 16'(k), 16'(4 * pwm_duty));
    end
    $display("output test done");
    {st_fn, tr_fn} = 4'h5;
    repeat (8)
    begin
      n = $random(seed);
      st_inv = n[1];
      i_stio_far_s.drv_lvl = n[0];
      tr_inv = n[3];
      i_stio_far_t.drv_lvl = n[2];
      cyc(4);
      chk("st_oe_n", st_pin_oe_n, 1'b1);
      chk("st_level", st_level, n[0] ^ n[1]);
      chk("tr_oe_n", tr_pin_oe_n, 1'b1);
      chk("tr_level", tr_level, n[2] ^ n[3]);
    end
    $display("input test done");
    {tr_fn, tr_dir_out} = 3'h7;
    for (k = 0; k < 2; k++)
    begin
      tr_inv = k[0];
      cyc(4);
      n = 0;
      for (int c = 0; c < 24; c++)
      begin
        trig_event = (c == 0 || c == 4);
        cyc(1);
        n += (tr_pin_out === tr_inv && tr_pin_oe_n === 1'b0);
      end
      chk("tr_low", 16'(n), 16'(LC));
    end
    $display("trigger out done");
    tr_dir_out = 1'b0;
    for (k = 0; k < 5; k++)
    begin
      tr_target = (k < 3) ? k[1:0] : 2'h0;
      meter_armed = (k != 3);
      i_stio_far_t.drv_lvl = !k[0];
      tr_inv = k[0];
      cyc(12);
      chk("tr_idle", tr_level, 1'b1);
      base = cnt;
      i_stio_far_t.pulse((k == 4) ? LC - 2 : LC + 6, tr_inv);
      cyc(20);
      m = cnt[tr_target] - base[tr_target];
      n = cnt[0] + cnt[1] + cnt[2] - base[0] - base[1] - base[2];
      chk("start", 16'(m), 16'(k < 3));
      chk("starts", 16'(n), 16'(k < 3));
    end
    $display("trigger in done");
    results();
  end
endmodule
